// ---- rtl/csd_divider.sv ----
// Glitch-free programmable divider producing an enable pulse and a clock level
`timescale 1ns/1ns
module csd_divider import csd_pkg::*; #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             src_en,
    input  wire logic [WIDTH-1:0] div,
    output logic                  tick,
    output logic                  level
);

    logic [WIDTH-1:0] cnt;                                 // Source ticks in period
    logic [WIDTH-1:0] ratio;                               // Divide value in use
    logic             wrap;                                // Last tick of the period
    logic [WIDTH-1:0] next_ratio;                          // Ratio for the next tick
    logic [WIDTH-1:0] next_cnt;                            // Count after this tick
    logic [WIDTH:0]   half;                                // High ticks per period

    // New divide value is taken only at a period boundary
    assign wrap       = (cnt == ratio);
    assign next_ratio = wrap ? div : ratio;
    assign next_cnt   = wrap ? '0 : WIDTH'(cnt + 1'b1);
    assign half       = (WIDTH+1)'(({1'b0, next_ratio} + (WIDTH+1)'(2)) >> 1);

    // Count source ticks, divide by value plus one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt   <= '0;
            ratio <= '0;
            tick  <= 1'b0;
            level <= 1'b0;
        end else begin
            tick <= src_en && wrap;
            if (src_en) begin
                cnt   <= next_cnt;
                ratio <= next_ratio;
                level <= ({1'b0, next_cnt} < half);
            end
        end
    end

endmodule

// ---- rtl/csd_pkg.sv ----
// Shared constants for the clock source and divider block
package csd_pkg;

    // Bus geometry
    localparam int AXI_AW = 20;                            // Byte address width
    localparam int AXI_DW = 32;                            // Data width

    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_SRC    = 16'h0012;         // Source select
    localparam logic [15:0] IDX_STATUS = 16'h001A;         // Live clock status
    localparam logic [15:0] IDX_MAIN   = 16'h0018;         // Main clock divider
    localparam logic [15:0] IDX_PANEL  = 16'h0030;         // Pixel and serial dividers
    localparam logic [15:0] IDX_CAM    = 16'h0100;         // Camera divider
    localparam logic [15:0] IDX_CARD   = 16'h6100;         // Card divider

    localparam logic [AXI_AW-1:0] ADDR_SRC    = AXI_AW'({IDX_SRC, 2'b00});
    localparam logic [AXI_AW-1:0] ADDR_STATUS = AXI_AW'({IDX_STATUS, 2'b00});
    localparam logic [AXI_AW-1:0] ADDR_MAIN   = AXI_AW'({IDX_MAIN, 2'b00});
    localparam logic [AXI_AW-1:0] ADDR_PANEL  = AXI_AW'({IDX_PANEL, 2'b00});
    localparam logic [AXI_AW-1:0] ADDR_CAM    = AXI_AW'({IDX_CAM, 2'b00});
    localparam logic [AXI_AW-1:0] ADDR_CARD   = AXI_AW'({IDX_CARD, 2'b00});

    // Field positions
    localparam int SRC_EN_BIT   = 0;                       // PLL enable
    localparam int SRC_SEL_BIT  = 2;                       // PLL select
    localparam int MAIN_LSB     = 0;                       // Main divide, 2 bits
    localparam int MAIN_W       = 2;
    localparam int PIX_LSB      = 0;                       // Pixel divide, 5 bits
    localparam int PIX_W        = 5;
    localparam int SER_LSB      = 8;                       // Serial divide, 3 bits
    localparam int SER_W        = 3;
    localparam int CAM_LSB      = 0;                       // Camera divide, 4 bits
    localparam int CAM_W        = 4;
    localparam int CAM_PIN_BIT  = 7;                       // Camera pin enable
    localparam int CARD_LSB     = 4;                       // Card divide, 4 bits
    localparam int CARD_W       = 4;

    // Reset values of the fields
    localparam logic [1:0]        RST_SRC     = 2'h0;
    localparam logic [MAIN_W-1:0] RST_MAIN    = 2'h0;
    localparam logic [PIX_W-1:0]  RST_PIX     = 5'h00;
    localparam logic [SER_W-1:0]  RST_SER     = 3'h0;
    localparam logic [CAM_W-1:0]  RST_CAM     = 4'h0;
    localparam logic              RST_CAM_PIN = 1'b0;
    localparam logic [CARD_W-1:0] RST_CARD    = 4'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [AXI_DW-1:0] ZERO_WORD = 32'h0000_0000;

endpackage

// ---- rtl/csd_top.sv ----
// Clock source selection, main divider and four derived clock dividers
`timescale 1ns/1ns
module csd_top import csd_pkg::*; (
    input  wire logic              MCLK,
    input  wire logic              RST,
    input  wire logic              EXT_CLOCK_INPUT,
    // AXI4-Lite write address
    input  wire logic [AXI_AW-1:0] S_AXI_AWADDR,
    input  wire logic [2:0]        S_AXI_AWPROT,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [AXI_DW-1:0] S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [AXI_AW-1:0] S_AXI_ARADDR,
    input  wire logic [2:0]        S_AXI_ARPROT,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [AXI_DW-1:0]      S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // Derived clocks as one-cycle enables and pin levels
    output logic                   MAIN_INTERNAL_CLOCK_EN,
    output logic                   PIXEL_CLOCK_EN,
    output logic                   SERIAL_CLOCK_EN,
    output logic                   CAMERA_BLOCK_CLOCK_EN,
    output logic                   CARD_CLOCK_EN,
    output logic                   CAMERA_MASTER_CLOCK_PIN,
    output logic                   CARD_CLOCK_PIN
);

    // Software-written fields
    logic [1:0]        src_sel;                            // {PLL select, PLL enable}
    logic [MAIN_W-1:0] main_div;                           // Main divide value
    logic [PIX_W-1:0]  pix_div;                            // Pixel divide value
    logic [SER_W-1:0]  ser_div;                            // Serial divide value
    logic [CAM_W-1:0]  cam_div;                            // Camera divide value
    logic              cam_pin_en;                         // Camera pin drive enable
    logic [CARD_W-1:0] card_div;                           // Card divide value

    // External clock synchroniser
    logic ext_s1;                                          // First stage, read by s2 only
    logic ext_s2;                                          // Second stage
    logic ext_s3;                                          // Third stage
    logic ext_level;                                       // Accepted input level
    logic ext_agree;                                       // Stages two and three match
    logic ext_rise;                                        // Accepted rising edge

    // Clock chain
    logic use_pll;                                         // PLL source chosen
    logic src_tick;                                        // Selected source enable
    logic main_tick;                                       // Main clock enable
    logic pix_tick;                                        // Pixel enable
    logic ser_tick;                                        // Serial enable
    logic cam_tick;                                        // Camera enable
    logic cam_level;                                       // Camera clock level
    logic card_tick;                                       // Card enable
    logic card_level;                                      // Card clock level

    // Bus state
    logic [AXI_AW-1:0] aw_addr;                            // Captured write address
    logic              aw_got;                             // Write address held
    logic [AXI_DW-1:0] w_data;                             // Captured write data
    logic [3:0]        w_strb;                             // Captured byte strobes
    logic              w_got;                              // Write data held
    logic              wr_fire;                            // Perform the write now

    // Write decode
    logic hit_src_w;
    logic hit_main_w;
    logic hit_panel_w;
    logic hit_cam_w;
    logic hit_card_w;
    logic hit_any_w;
    logic [AXI_DW-1:0] wr_mask;                            // Byte strobes as bit mask

    // Read decode and data
    logic [AXI_DW-1:0] rd_src;
    logic [AXI_DW-1:0] rd_main;
    logic [AXI_DW-1:0] rd_panel;
    logic [AXI_DW-1:0] rd_cam;
    logic [AXI_DW-1:0] rd_card;
    logic [AXI_DW-1:0] rd_status;
    logic [AXI_DW-1:0] rd_data;
    logic              rd_hit;
    logic [AXI_DW-1:0] old_word;                           // Current value at write address
    logic [AXI_DW-1:0] new_word;                           // Merged value to store

    // Byte strobes spread over their lanes
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign wr_mask[8*g +: 8] = {8{w_strb[g]}};
        end
    endgenerate

    // Register images, reserved bits zero
    assign rd_src    = AXI_DW'({src_sel[1], 1'b0, src_sel[0]});
    assign rd_main   = AXI_DW'(main_div) << MAIN_LSB;
    assign rd_panel  = (AXI_DW'(ser_div) << SER_LSB) | (AXI_DW'(pix_div) << PIX_LSB);
    assign rd_cam    = (AXI_DW'(cam_pin_en) << CAM_PIN_BIT) | (AXI_DW'(cam_div) << CAM_LSB);
    assign rd_card   = AXI_DW'(card_div) << CARD_LSB;
    assign rd_status = AXI_DW'({card_level, cam_level, ext_level, use_pll});

    // Write address decode
    assign hit_src_w   = (aw_addr == ADDR_SRC);
    assign hit_main_w  = (aw_addr == ADDR_MAIN);
    assign hit_panel_w = (aw_addr == ADDR_PANEL);
    assign hit_cam_w   = (aw_addr == ADDR_CAM);
    assign hit_card_w  = (aw_addr == ADDR_CARD);
    assign hit_any_w   = hit_src_w | hit_main_w | hit_panel_w | hit_cam_w | hit_card_w;
    assign wr_fire     = aw_got && w_got && !S_AXI_BVALID;

    // Merge written bytes into the current word
    assign old_word = hit_src_w   ? rd_src   :
                      hit_main_w  ? rd_main  :
                      hit_panel_w ? rd_panel :
                      hit_cam_w   ? rd_cam   :
                      hit_card_w  ? rd_card  : ZERO_WORD;
    assign new_word = (w_data & wr_mask) | (old_word & ~wr_mask);

    // Read address decode
    assign rd_data = (S_AXI_ARADDR == ADDR_SRC)    ? rd_src    :
                     (S_AXI_ARADDR == ADDR_MAIN)   ? rd_main   :
                     (S_AXI_ARADDR == ADDR_PANEL)  ? rd_panel  :
                     (S_AXI_ARADDR == ADDR_CAM)    ? rd_cam    :
                     (S_AXI_ARADDR == ADDR_CARD)   ? rd_card   :
                     (S_AXI_ARADDR == ADDR_STATUS) ? rd_status : ZERO_WORD;
    assign rd_hit  = (S_AXI_ARADDR == ADDR_SRC)  || (S_AXI_ARADDR == ADDR_MAIN) ||
                     (S_AXI_ARADDR == ADDR_PANEL) || (S_AXI_ARADDR == ADDR_CAM) ||
                     (S_AXI_ARADDR == ADDR_CARD)  || (S_AXI_ARADDR == ADDR_STATUS);

    // Write channel: capture address and data in any order, then answer
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_addr       <= S_AXI_AWADDR;
                aw_got        <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_data       <= S_AXI_WDATA;
                w_strb       <= S_AXI_WSTRB;
                w_got        <= 1'b1;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= hit_any_w ? RESP_OKAY : RESP_SLVERR;
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // Read channel: one-cycle answer, unmapped reads give zero and error
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= ZERO_WORD;
            S_AXI_RRESP   <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_data;
            S_AXI_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // Setting registers, written through byte lanes
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            src_sel    <= RST_SRC;
            main_div   <= RST_MAIN;
            pix_div    <= RST_PIX;
            ser_div    <= RST_SER;
            cam_div    <= RST_CAM;
            cam_pin_en <= RST_CAM_PIN;
            card_div   <= RST_CARD;
        end else if (wr_fire) begin
            if (hit_src_w) begin
                src_sel <= {new_word[SRC_SEL_BIT], new_word[SRC_EN_BIT]};
            end
            if (hit_main_w) begin
                main_div <= new_word[MAIN_LSB +: MAIN_W];
            end
            if (hit_panel_w) begin
                pix_div <= new_word[PIX_LSB +: PIX_W];
                ser_div <= new_word[SER_LSB +: SER_W];
            end
            if (hit_cam_w) begin
                cam_div    <= new_word[CAM_LSB +: CAM_W];
                cam_pin_en <= new_word[CAM_PIN_BIT];
            end
            if (hit_card_w) begin
                card_div <= new_word[CARD_LSB +: CARD_W];
            end
        end
    end

    // External clock input: three stages, a change counts when two and three agree
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ext_s1    <= 1'b0;
            ext_s2    <= 1'b0;
            ext_s3    <= 1'b0;
            ext_level <= 1'b0;
        end else begin
            ext_s1 <= EXT_CLOCK_INPUT;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            if (ext_agree) begin
                ext_level <= ext_s3;
            end
        end
    end

    assign ext_agree = (ext_s2 == ext_s3);
    assign ext_rise  = ext_agree && ext_s3 && !ext_level;

    // Source choice: PLL needs both enable and select, otherwise external input
    assign use_pll  = src_sel[1] && src_sel[0];
    assign src_tick = use_pll ? 1'b1 : ext_rise;

    // Main internal clock divider
    csd_divider #(.WIDTH(MAIN_W)) u_main (
        .clk    (MCLK),
        .rst    (RST),
        .src_en (src_tick),
        .div    (main_div),
        .tick   (main_tick),
        .level  ()
    );

    // Pixel clock divider from the main clock
    csd_divider #(.WIDTH(PIX_W)) u_pix (
        .clk    (MCLK),
        .rst    (RST),
        .src_en (main_tick),
        .div    (pix_div),
        .tick   (pix_tick),
        .level  ()
    );

    // Serial clock divider from the main clock
    csd_divider #(.WIDTH(SER_W)) u_ser (
        .clk    (MCLK),
        .rst    (RST),
        .src_en (main_tick),
        .div    (ser_div),
        .tick   (ser_tick),
        .level  ()
    );

    // Camera clock divider; value one gives two-to-one
    csd_divider #(.WIDTH(CAM_W)) u_cam (
        .clk    (MCLK),
        .rst    (RST),
        .src_en (main_tick),
        .div    (cam_div),
        .tick   (cam_tick),
        .level  (cam_level)
    );

    // Memory card clock divider
    csd_divider #(.WIDTH(CARD_W)) u_card (
        .clk    (MCLK),
        .rst    (RST),
        .src_en (main_tick),
        .div    (card_div),
        .tick   (card_tick),
        .level  (card_level)
    );

    // Output flops: enables delayed one cycle, card pin follows its divider level, camera pin its level gated by cam_pin_en
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            MAIN_INTERNAL_CLOCK_EN  <= 1'b0;
            PIXEL_CLOCK_EN          <= 1'b0;
            SERIAL_CLOCK_EN         <= 1'b0;
            CAMERA_BLOCK_CLOCK_EN   <= 1'b0;
            CARD_CLOCK_EN           <= 1'b0;
            CAMERA_MASTER_CLOCK_PIN <= 1'b0;
            CARD_CLOCK_PIN          <= 1'b0;
        end else begin
            MAIN_INTERNAL_CLOCK_EN  <= main_tick;
            PIXEL_CLOCK_EN          <= pix_tick;
            SERIAL_CLOCK_EN         <= ser_tick;
            CAMERA_BLOCK_CLOCK_EN   <= cam_tick;
            CARD_CLOCK_EN           <= card_tick;
            CAMERA_MASTER_CLOCK_PIN <= cam_pin_en && cam_level;
            CARD_CLOCK_PIN          <= card_level;
        end
    end

endmodule

// ---- sim/csd_monitor.sv ----
// Checker of bus handshakes and of derived clock enable timing
`timescale 1ns/1ns
module csd_monitor import csd_pkg::*; (
    input wire logic              MCLK,
    input wire logic              RST,
    input wire logic              S_AXI_AWREADY,
    input wire logic              S_AXI_WREADY,
    input wire logic [1:0]        S_AXI_BRESP,
    input wire logic              S_AXI_BVALID,
    input wire logic              S_AXI_BREADY,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic [AXI_DW-1:0] S_AXI_RDATA,
    input wire logic              S_AXI_RVALID,
    input wire logic              S_AXI_RREADY,
    input wire logic              MAIN_INTERNAL_CLOCK_EN,
    input wire logic              PIXEL_CLOCK_EN,
    input wire logic              SERIAL_CLOCK_EN,
    input wire logic              CAMERA_BLOCK_CLOCK_EN,
    input wire logic              CARD_CLOCK_EN
);
    // One clock domain, checks idle during reset
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // Responses stand until taken
    property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped early");
    // Response only after both halves of a write are taken
    property p_bwait; $rose(S_AXI_BVALID) |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_bwait: assert property (p_bwait) else $error("write response before both halves");
    // Read answers one cycle after the address is taken
    property p_rans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    // Each derived clock is paced by the main clock
    property p_pix; PIXEL_CLOCK_EN |-> $past(MAIN_INTERNAL_CLOCK_EN); endproperty
    a_pix: assert property (p_pix) else $error("pixel tick without main tick");
    property p_ser; SERIAL_CLOCK_EN |-> $past(MAIN_INTERNAL_CLOCK_EN); endproperty
    a_ser: assert property (p_ser) else $error("serial tick without main tick");
    property p_cam; CAMERA_BLOCK_CLOCK_EN |-> $past(MAIN_INTERNAL_CLOCK_EN); endproperty
    a_cam: assert property (p_cam) else $error("camera tick without main tick");
    property p_card; CARD_CLOCK_EN |-> $past(MAIN_INTERNAL_CLOCK_EN); endproperty
    a_card: assert property (p_card) else $error("card tick without main tick");
    // Main scenarios reached
    cover property (S_AXI_BVALID && S_AXI_BREADY);
    cover property (S_AXI_RVALID && S_AXI_RREADY);
    cover property (CAMERA_BLOCK_CLOCK_EN && !MAIN_INTERNAL_CLOCK_EN);
endmodule

bind csd_top csd_monitor u_mon (.MCLK, .RST, .S_AXI_AWREADY, .S_AXI_WREADY, .S_AXI_BRESP,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RVALID, .S_AXI_RREADY, .MAIN_INTERNAL_CLOCK_EN, .PIXEL_CLOCK_EN,
    .SERIAL_CLOCK_EN, .CAMERA_BLOCK_CLOCK_EN, .CARD_CLOCK_EN);

// ---- sim/csd_peer_model.sv ----
// Camera module or card model that measures the period of its clock pin
`timescale 1ns/1ns
module csd_peer_model (
    input  wire logic clk,
    input  wire logic pin,
    output int        per
);
    int   cnt  = 0;      // Cycles since the last rising edge
    logic last = 1'b0;   // Pin one cycle ago
    // Period restarts at each rising edge of the received clock
    always @(posedge clk) begin
        last <= pin;
        cnt  <= (pin && !last) ? 1 : cnt + 1;
        if (pin && !last) per <= cnt;
    end
endmodule

// ---- sim/test_clock_source_dividers.sv ----
// Self-checking bench for the clock source and divider block
`timescale 1ns/1ns
module test_clock_source_dividers import csd_pkg::*;;
    logic              clk = 1'b0, rst = 1'b1, ext = 1'b0;  // Clock, reset, external clock
    logic              awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [AXI_AW-1:0] awaddr = '0, araddr = '0;             // Bus addresses
    logic [31:0]       wdata = '0, rdata;                    // Bus data
    logic              awr, wrdy, bv, arr, rv, cam_pin, card_pin;
    logic [1:0]        bresp, rresp;
    wire  [4:0]        ens;                                  // Card, camera, serial, pixel, main
    int                err_count = 0, num_checks = 0, ext_cnt = 0, cam_per, card_per;

    csd_top dut_u (.MCLK(clk), .RST(rst), .EXT_CLOCK_INPUT(ext), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .MAIN_INTERNAL_CLOCK_EN(ens[0]),
        .PIXEL_CLOCK_EN(ens[1]), .SERIAL_CLOCK_EN(ens[2]), .CAMERA_BLOCK_CLOCK_EN(ens[3]),
        .CARD_CLOCK_EN(ens[4]), .CAMERA_MASTER_CLOCK_PIN(cam_pin), .CARD_CLOCK_PIN(card_pin));
    csd_peer_model cam_u (.clk(clk), .pin(cam_pin), .per(cam_per));
    csd_peer_model card_u (.clk(clk), .pin(card_pin), .per(card_per));

    // 20 MHz clock; external clock input toggles every 5 cycles
    always #25 clk = ~clk;
    always @(posedge clk) begin
        ext_cnt <= (ext_cnt == 4) ? 0 : ext_cnt + 1;
        if (ext_cnt == 4) ext <= ~ext;
    end

    // Comparisons
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t word %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            err_count++;
            $display("FAIL %0t count %0d want %0d", $time, got, exp);
        end
    endtask

    // Bus write with expected response; both halves offered together
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
        end while (!(bready && bv));
        check_word(32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask
    // Bus read with expected response
    task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!(rready && rv));
        d = rdata;
        check_word(32'(rresp), 32'(er));
        rready <= 1'b0;
    endtask
    // Cycles between two pulses of one enable
    task automatic measure(input int s, output int p);
        int n = 0;
        p = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ens[s] !== 1'b1 && n < 4000);
        do begin
            @(posedge clk);
            p++;
        end while (ens[s] !== 1'b1 && p < 4000);
    endtask
    task automatic period(input int s, input int exp);
        int p;
        measure(s, p);
        measure(s, p);
        check_count(p, exp);
    endtask

    // Reset values, unmapped and read-only places
    task automatic t_reset();
        logic [31:0] d;
        logic [AXI_AW-1:0] regs [5] = '{ADDR_SRC, ADDR_MAIN, ADDR_PANEL, ADDR_CAM, ADDR_CARD};
        foreach (regs[i]) begin
            rd(regs[i], d, RESP_OKAY);
            check_word(d, ZERO_WORD);
        end
        rd(20'h0_0044, d, RESP_SLVERR);
        check_word(d, ZERO_WORD);
        wr(20'h0_0044, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h0000_0005, RESP_SLVERR);
        rd(ADDR_SRC, d, RESP_OKAY);
        check_word(d, ZERO_WORD);
        $display("t_reset done");
    endtask
    // PLL source, every main divide, clean change of ratio
    task automatic t_main();
        logic [31:0] d;
        int p;
        wr(ADDR_SRC, 32'h0000_0005, RESP_OKAY);
        rd(ADDR_STATUS, d, RESP_OKAY);
        check_word(d & 32'h0000_0001, 32'h0000_0001);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_MAIN, 32'(m), RESP_OKAY);
            measure(0, p);
            check_count((p == m || p == m + 1) ? 1 : 0, 1);
            period(0, m + 1);
        end
        $display("t_main done");
    endtask
    // Derived dividers at main ratio 2, pixel at its largest field
    task automatic t_derived();
        wr(ADDR_MAIN, 32'h0000_0001, RESP_OKAY);
        wr(ADDR_PANEL, 32'h0000_051F, RESP_OKAY);
        wr(ADDR_CAM, 32'h0000_0003, RESP_OKAY);
        wr(ADDR_CARD, 32'h0000_0090, RESP_OKAY);
        period(1, 64);
        period(2, 12);
        period(3, 8);
        period(4, 20);
        $display("t_derived done");
    endtask
    // Camera and card pins as seen by the attached parts
    task automatic t_pins();
        wr(ADDR_MAIN, ZERO_WORD, RESP_OKAY);
        wr(ADDR_CAM, 32'h0000_0081, RESP_OKAY);
        period(3, 2);
        repeat (40) @(posedge clk);
        check_count(cam_per, 2);
        check_count(card_per, 10);
        wr(ADDR_CAM, 32'h0000_0001, RESP_OKAY);
        repeat (10) @(posedge clk);
        check_word(32'(cam_pin), ZERO_WORD);
        $display("t_pins done");
    endtask
    // External source whenever the PLL is not both enabled and selected
    task automatic t_ext();
        logic [31:0] srcs [3] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0004};
        foreach (srcs[i]) begin
            wr(ADDR_SRC, srcs[i], RESP_OKAY);
            period(0, 10);
        end
        $display("t_ext done");
    endtask

    // Verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence after 3 cycles of reset
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_main();
        t_derived();
        t_pins();
        t_ext();
        print_verdict();
    end
    // Watchdog well beyond the expected run
    initial begin
        #3000000;
        err_count++;
        print_verdict();
    end
endmodule
